// [rims_pkg.sv]
// Constants for the radio interrupt mapping and status block.
// Assumes a single 40 MHz core clock and an Avalon-MM register slave.
//
// How it works
// - Rx continuous: pin A pattern, level, start
// - Rx buffered: pin A low, byte, nonempty, start
// - Rx packet: pin A ready, byte, nonempty, match/start
// - Rx continuous: pin B carries recovered clock
// - Rx buffered: pin B low, full, level, threshold
// - Rx packet: pin B crc, full, level, threshold
// - Tx pin A: zero, threshold or nonempty
// - Tx pin B: clock or full; finished never chosen, bit 2 not writable
// - Queue full readable at bit 1
// - Queue not-empty flag at bit 0, high when the queue holds data
// - Fill mode bit 7 chooses fill start
// - Fill-start bit 6 set by start detect, rearmed
// - Transmit-done bit 5, read only
// - Overflow bit 4, write one empties queue in buffered or packet mode
// - Packet mode: write one allows new packet
// - Bit 3 enables level detect
// - Level detect sticky, write one clears
// - Lock sticky latches, write one clears
// - Lock output enable; disabled pin held high
// - Threshold register, eight bits, resets zero
// - Threshold event at programmed plus one bytes
package rims_pkg;
    // ------------------------------------------------------------------
    // Register map (word index, byte address is four times)
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_PIN_SEL  = 4'hd;
    localparam logic [3:0] IDX_STATUS   = 4'he;
    localparam logic [3:0] IDX_THRESH   = 4'hf;
    localparam logic [7:0] RST_PIN_SEL  = 8'h00;
    localparam logic [7:0] RST_STATUS   = 8'h01;
    localparam logic [7:0] RST_THRESH   = 8'h00;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int B_RXA_HI    = 7;
    localparam int B_RXA_LO    = 6;
    localparam int B_RXB_HI    = 5;
    localparam int B_RXB_LO    = 4;
    localparam int B_TXA       = 3;
    localparam int B_TXB       = 2;
    localparam int B_FULL      = 1;
    localparam int B_NEMPTY_N  = 0;
    localparam int B_FILL_MODE = 7;
    localparam int B_FILL_GO   = 6;
    localparam int B_TX_DONE   = 5;
    localparam int B_OVR       = 4;
    localparam int B_LVL_EN    = 3;
    localparam int B_LVL_FLAG  = 2;
    localparam int B_LOCK_ST   = 1;
    localparam int B_LOCK_EN   = 0;
    localparam logic [7:0] PIN_SEL_WMASK = 8'hf8;
    // ------------------------------------------------------------------
    // Modes and bus answer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RIMS_CONT = 2'b00,
        RIMS_BUFF = 2'b01,
        RIMS_PKT  = 2'b11
    } rims_mode_e;
    localparam logic [1:0] SEL_0 = 2'b00;
    localparam logic [1:0] SEL_1 = 2'b01;
    localparam logic [1:0] SEL_2 = 2'b10;
    localparam logic [1:0] SEL_3 = 2'b11;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage

// [rims_sync.sv]
// Three-stage input synchroniser for pins from other clock domains.
// Assumes the core clock; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rims_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign q_o = out_q;
endmodule // rims_sync
`default_nettype wire

// [rims_top.sv]
// Interrupt pin routing, sticky status and level threshold registers.
// Event sources live outside; their levels and pulses are core-clocked
// except the lock and recovered clock, which come from other domains.
`timescale 1ns/1ps
`default_nettype none
module rims_top #(
    parameter int QW = 7
) (
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    // Avalon-MM slave
    input  wire logic [5:0]    avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic      [31:0]   avs_readdata_o,
    output logic               avs_waitrequest_o,
    // Operating context
    input  wire logic          tx_mode_i,
    input  wire logic [1:0]    data_mode_i,
    input  wire logic          standby_i,
    input  wire logic          node_match_enable_i,
    // Event sources
    input  wire logic          pattern_sig_i,
    input  wire logic          start_detect_i,
    input  wire logic          data_ready_i,
    input  wire logic          byte_written_i,
    input  wire logic          crc_ok_i,
    input  wire logic          node_match_i,
    input  wire logic          queue_full_flag_i,
    input  wire logic [QW-1:0] queue_count_i,
    input  wire logic [5:0]    queue_thresh_i,
    input  wire logic          tx_bits_done_i,
    input  wire logic          queue_overflow_i,
    input  wire logic [7:0]    level_i,
    input  wire logic          synth_lock_i,
    input  wire logic          recovered_bit_clock_i,
    // Results
    output logic               host_int_pin_a_o,
    output logic               host_int_pin_b_o,
    output logic               fill_enable_o,
    output logic               queue_flush_o,
    output logic               lock_pin_o,
    output logic [7:0]         level_threshold_o
);
    // ------------------------------------------------------------------
    // Registers and synchronised pins
    // ------------------------------------------------------------------
    logic [7:0] pin_sel_q;
    logic [7:0] status_q;
    logic [7:0] thresh_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic        lock_s;
    logic        bclk_s;
    logic        lock_prev_q;
    logic        lvl_prev_q;
    logic        pin_a_q;
    logic        pin_b_q;
    logic        flush_q;

    localparam int B_RXA_HI    = rims_pkg::B_RXA_HI;
    localparam int B_RXA_LO    = rims_pkg::B_RXA_LO;
    localparam int B_RXB_HI    = rims_pkg::B_RXB_HI;
    localparam int B_RXB_LO    = rims_pkg::B_RXB_LO;
    localparam int B_TXA       = rims_pkg::B_TXA;
    localparam int B_TXB       = rims_pkg::B_TXB;
    localparam int B_FILL_MODE = rims_pkg::B_FILL_MODE;
    localparam int B_FILL_GO   = rims_pkg::B_FILL_GO;
    localparam int B_TX_DONE   = rims_pkg::B_TX_DONE;
    localparam int B_OVR       = rims_pkg::B_OVR;
    localparam int B_LVL_EN    = rims_pkg::B_LVL_EN;
    localparam int B_LVL_FLAG  = rims_pkg::B_LVL_FLAG;
    localparam int B_LOCK_ST   = rims_pkg::B_LOCK_ST;
    localparam int B_LOCK_EN   = rims_pkg::B_LOCK_EN;
    localparam logic [1:0] RIMS_PKT_V  = rims_pkg::RIMS_PKT;
    localparam logic [1:0] RIMS_BUFF_V = rims_pkg::RIMS_BUFF;
    localparam logic [1:0] RIMS_CONT_V = rims_pkg::RIMS_CONT;

    // Buffered or packet; code 10 counts as continuous
    function automatic logic framed(input logic [1:0] m);
        framed = (m == RIMS_BUFF_V) | (m == RIMS_PKT_V);
    endfunction

    rims_sync #(.W(2)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .d_i        ({synth_lock_i, recovered_bit_clock_i}),
        .q_o        ({lock_s, bclk_s})
    );

    // Register index from byte address
    function automatic logic [3:0] reg_idx(input logic [5:0] a);
        reg_idx = a[5:2];
    endfunction

    logic req;
    logic wr_go;
    logic [7:0] wd;
    assign req   = (avs_read_i | avs_write_i) & ~ack_q;
    assign wr_go = avs_write_i & ~ack_q & avs_byteenable_i[0];
    assign wd    = avs_writedata_i[7:0];

    // ------------------------------------------------------------------
    // Derived status
    // ------------------------------------------------------------------
    logic nempty_n;
    logic thr_hit;
    logic lvl_hit;
    logic lvl_rise;
    logic lock_rise;
    logic pkt;
    assign nempty_n  = (queue_count_i != '0);
    assign thr_hit   = queue_count_i >= QW'({1'b0, queue_thresh_i} + 7'h01);
    assign lvl_hit   = level_i >= thresh_q;
    assign lvl_rise  = lvl_hit & ~lvl_prev_q & status_q[B_LVL_EN];
    assign lock_rise = lock_s & ~lock_prev_q;
    assign pkt       = (data_mode_i == RIMS_PKT_V);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            lock_prev_q <= 1'b0;
            lvl_prev_q  <= 1'b0;
        end else begin
            lock_prev_q <= lock_s;
            lvl_prev_q  <= lvl_hit;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave: one wait cycle, then answer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (avs_read_i & ~ack_q) begin
                case (reg_idx(avs_address_i))
                    rims_pkg::IDX_PIN_SEL: begin
                        rdata_q <= {24'h00_0000, pin_sel_q[7:2],
                                    queue_full_flag_i, nempty_n};
                    end
                    rims_pkg::IDX_STATUS: begin
                        rdata_q <= {24'h00_0000, status_q};
                    end
                    rims_pkg::IDX_THRESH: begin
                        rdata_q <= {24'h00_0000, thresh_q};
                    end
                    default: begin
                        rdata_q <= rims_pkg::UNMAPPED_RD;
                    end
                endcase
            end
        end
    end

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rdata_q;

    // ------------------------------------------------------------------
    // Pin source select and threshold registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_sel_q <= rims_pkg::RST_PIN_SEL;
            thresh_q  <= rims_pkg::RST_THRESH;
        end else if (wr_go) begin
            if (reg_idx(avs_address_i) == rims_pkg::IDX_PIN_SEL) begin
                pin_sel_q <= wd & rims_pkg::PIN_SEL_WMASK;
            end
            if (reg_idx(avs_address_i) == rims_pkg::IDX_THRESH) begin
                thresh_q <= wd;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status and control register
    // ------------------------------------------------------------------
    logic st_wr;
    assign st_wr = wr_go & (reg_idx(avs_address_i) == rims_pkg::IDX_STATUS);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_q <= rims_pkg::RST_STATUS;
        end else begin
            if (st_wr) begin
                status_q[B_FILL_MODE] <= wd[B_FILL_MODE];
                status_q[B_LVL_EN]    <= wd[B_LVL_EN];
                status_q[B_LOCK_EN]   <= wd[B_LOCK_EN];
            end
            status_q[B_TX_DONE] <= tx_bits_done_i;
            // Fill-start: start detect sets it in mode 0, host writes it in 1
            if (status_q[B_FILL_MODE]) begin
                if (st_wr) begin
                    status_q[B_FILL_GO] <= wd[B_FILL_GO];
                end
            end else if (start_detect_i) begin
                status_q[B_FILL_GO] <= 1'b1;
            end else if (st_wr & wd[B_FILL_GO]) begin
                status_q[B_FILL_GO] <= 1'b0;
            end
            if (queue_overflow_i) begin
                status_q[B_OVR] <= 1'b1;
            end else if (st_wr & wd[B_OVR]) begin
                status_q[B_OVR] <= 1'b0;
            end
            if (lvl_rise) begin
                status_q[B_LVL_FLAG] <= 1'b1;
            end else if (st_wr & wd[B_LVL_FLAG]) begin
                status_q[B_LVL_FLAG] <= 1'b0;
            end
            if (lock_rise) begin
                status_q[B_LOCK_ST] <= 1'b1;
            end else if (st_wr & wd[B_LOCK_ST]) begin
                status_q[B_LOCK_ST] <= 1'b0;
            end
        end
    end

    // Overflow write of one empties the queue in buffered or packet mode
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= st_wr & wd[B_OVR]
                       & framed(data_mode_i);
        end
    end

    // ------------------------------------------------------------------
    // Interrupt pin routing
    // ------------------------------------------------------------------
    logic pin_a_d;
    logic pin_b_d;
    logic [1:0] rxa;
    logic [1:0] rxb;
    assign rxa = pin_sel_q[B_RXA_HI:B_RXA_LO];
    assign rxb = pin_sel_q[B_RXB_HI:B_RXB_LO];

    always_comb begin
        pin_a_d = 1'b0;
        pin_b_d = 1'b0;
        if (tx_mode_i) begin
            if (!framed(data_mode_i)) begin
                pin_a_d = 1'b0;
                pin_b_d = bclk_s;
            end else begin
                pin_a_d = pin_sel_q[B_TXA] ? nempty_n : thr_hit;
                pin_b_d = pin_sel_q[B_TXB] ? status_q[B_TX_DONE]
                                           : queue_full_flag_i;
            end
        end else begin
            case (data_mode_i)
                RIMS_BUFF_V: begin
                    case (rxa)
                        rims_pkg::SEL_0: pin_a_d = 1'b0;
                        rims_pkg::SEL_1: pin_a_d = byte_written_i;
                        rims_pkg::SEL_2: pin_a_d = nempty_n;
                        default:         pin_a_d = start_detect_i;
                    endcase
                    case (rxb)
                        rims_pkg::SEL_0: pin_b_d = 1'b0;
                        rims_pkg::SEL_1: pin_b_d = queue_full_flag_i;
                        rims_pkg::SEL_2: pin_b_d = status_q[B_LVL_FLAG];
                        default:         pin_b_d = thr_hit;
                    endcase
                end
                RIMS_PKT_V: begin
                    case (rxa)
                        rims_pkg::SEL_0: pin_a_d = data_ready_i;
                        rims_pkg::SEL_1: pin_a_d = byte_written_i;
                        rims_pkg::SEL_2: pin_a_d = nempty_n;
                        default: pin_a_d = node_match_enable_i ? node_match_i
                                                               : start_detect_i;
                    endcase
                    case (rxb)
                        rims_pkg::SEL_0: pin_b_d = crc_ok_i;
                        rims_pkg::SEL_1: pin_b_d = queue_full_flag_i;
                        rims_pkg::SEL_2: pin_b_d = status_q[B_LVL_FLAG];
                        default:         pin_b_d = thr_hit;
                    endcase
                end
                default: begin
                    case (rxa)
                        rims_pkg::SEL_0: pin_a_d = pattern_sig_i;
                        rims_pkg::SEL_1: pin_a_d = status_q[B_LVL_FLAG];
                        default:         pin_a_d = start_detect_i;
                    endcase
                    pin_b_d = bclk_s;
                end
            endcase
        end
        // Standby keeps only the sources flagged as standby capable
        if (standby_i) begin
            pin_a_d = pin_a_d & ~tx_mode_i & framed(data_mode_i)
                      & (rxa == rims_pkg::SEL_2);
            pin_b_d = pin_b_d & ~tx_mode_i & framed(data_mode_i)
                      & ((rxb == rims_pkg::SEL_3)
                         | (pkt & (rxb == rims_pkg::SEL_1)));
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_a_q <= 1'b0;
            pin_b_q <= 1'b0;
        end else begin
            pin_a_q <= pin_a_d;
            pin_b_q <= pin_b_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign host_int_pin_a_o  = pin_a_q;
    assign host_int_pin_b_o  = pin_b_q;
    assign fill_enable_o     = status_q[B_FILL_GO];
    assign queue_flush_o     = flush_q;
    assign lock_pin_o        = status_q[B_LOCK_EN] ? lock_s : 1'b1;
    assign level_threshold_o = thresh_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    lock_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        lock_rise |=> status_q[B_LOCK_ST])
        else $error("lock sticky not set");
    lvl_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (status_q[B_LVL_FLAG] && !(st_wr && wd[B_LVL_FLAG])) |=> status_q[B_LVL_FLAG])
        else $error("level flag dropped");
    lvl_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!status_q[B_LVL_EN] && !status_q[B_LVL_FLAG]) |=> !status_q[B_LVL_FLAG])
        else $error("level flag set while disabled");
    lock_pin_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !status_q[B_LOCK_EN] |-> lock_pin_o)
        else $error("lock pin not high");
    tx_cont_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (tx_mode_i && data_mode_i == RIMS_CONT_V) |=> !host_int_pin_a_o)
        else $error("tx pin a not zero");
    buf_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!tx_mode_i && data_mode_i == RIMS_BUFF_V && rxa == rims_pkg::SEL_0)
        |=> !host_int_pin_a_o)
        else $error("buffered pin a not low");
    ovr_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        queue_overflow_i |=> status_q[B_OVR])
        else $error("overflow lost");
    flush_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (st_wr && wd[B_OVR] && pkt) |=> queue_flush_o)
        else $error("no flush");
    fill_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!status_q[B_FILL_MODE] && start_detect_i) |=> status_q[B_FILL_GO])
        else $error("fill start not set");
    thr_rst_a: assert property (@(posedge core_clk_i)
        $past(rst_i) |-> thresh_q == rims_pkg::RST_THRESH)
        else $error("threshold reset");
endmodule // rims_top
`default_nettype wire

// [rims_host.sv]
// Host-side model watching the two interrupt pins.
// Assumes pins are core-clocked outputs of the mapping block.
`timescale 1ns/1ps
`default_nettype none
module rims_host (
    input  wire logic clk_i,
    input  wire logic tx_mode_i,
    input  wire logic pin_a_i,
    input  wire logic pin_b_i,
    output int        tx_starts_o,
    output int        b_rises_o
);
    logic a_q = 1'b0;
    logic b_q = 1'b0;
    // Host starts a transmit on each rise of pin A while in transmit mode
    always @(posedge clk_i) begin
        a_q <= pin_a_i;
        b_q <= pin_b_i;
        if (tx_mode_i && pin_a_i === 1'b1 && a_q === 1'b0)
            tx_starts_o <= tx_starts_o + 1;
        if (pin_b_i === 1'b1 && b_q === 1'b0)
            b_rises_o <= b_rises_o + 1;
    end
    initial tx_starts_o = 0;
    initial b_rises_o = 0;
endmodule // rims_host
`default_nettype wire

// [tb.sv]
// Self-checking bench for the interrupt mapping and status block.
// Assumes rims_pkg, rims_sync, rims_top and rims_host compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, rd = 0, wr = 0, txm = 0, sby = 0, nme = 0;
    logic [5:0] adr = 0, thr = 0;
    logic [31:0] wd = 0, rdat, seed = 32'h8b99, r;
    logic [1:0] dm = 0;
    logic pat = 0, sdet = 0, drdy = 0, byt = 0, crc = 0, nm = 0;
    logic full = 0, txd = 0, ovr = 0, lock = 0, rclk = 0;
    logic [6:0] cnt = 0;
    logic [7:0] lvl = 0, t;
    logic [1:0] a, b, e;
    logic ta;
    wire logic [31:0] rdo;
    wire logic [7:0] lthr;
    wire logic wreq, pa, pb, fen, flu, lpin;
    int num_errors = 0, compares = 0, cyc = 0, fcnt = 0, f0, ts, br;
    always #12.5 clk = ~clk;
    rims_top dut_u (.core_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
        .avs_waitrequest_o(wreq), .tx_mode_i(txm), .data_mode_i(dm),
        .standby_i(sby), .node_match_enable_i(nme), .pattern_sig_i(pat),
        .start_detect_i(sdet), .data_ready_i(drdy), .byte_written_i(byt),
        .crc_ok_i(crc), .node_match_i(nm), .queue_full_flag_i(full),
        .queue_count_i(cnt), .queue_thresh_i(thr), .tx_bits_done_i(txd),
        .queue_overflow_i(ovr), .level_i(lvl), .synth_lock_i(lock),
        .recovered_bit_clock_i(rclk), .host_int_pin_a_o(pa),
        .host_int_pin_b_o(pb), .fill_enable_o(fen), .queue_flush_o(flu),
        .lock_pin_o(lpin), .level_threshold_o(lthr));
    rims_host host_u (.clk_i(clk), .tx_mode_i(txm), .pin_a_i(pa),
        .pin_b_i(pb), .tx_starts_o(ts), .b_rises_o(br));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (flu === 1'b1) fcnt <= fcnt + 1;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    // ------------------------------------------------------------------
    // Bus cycles, comparison and expected pins
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [3:0] i,
                       input logic [7:0] d);
        adr <= {i, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {24'h0, d};
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        rdat = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic rc(input logic [3:0] i, input logic [7:0] x);
        bus(1'b0, i, 8'h00);
        chk("reg", rdat, {24'h0, x});
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [1:0] pins(logic [1:0] sa, sb, logic st);
        logic ne, te, fr, pa_e, pb_e;
        logic [3:0] ra, rb;
        ne = cnt != 7'h00;
        te = cnt > {1'b0, thr};
        fr = dm == 2'b01 || dm == 2'b11;
        case (dm)
            2'b01: begin
                ra = {sdet, ne, byt, 1'b0};
                rb = {te, 1'b0, full, 1'b0};
            end
            2'b11: begin
                ra = {nme ? nm : sdet, ne, byt, drdy};
                rb = {te, 1'b0, full, crc};
            end
            default: begin
                ra = {sdet, sdet, 1'b0, pat};
                rb = {4{rclk}};
            end
        endcase
        pa_e = txm ? fr && (st ? ne : te) : ra[sa];
        pb_e = txm ? (fr ? full : rclk) : rb[sb];
        if (sby) begin
            pa_e = pa_e && !txm && fr && sa == 2'd2;
            pb_e = pb_e && !txm && fr
                   && (sb == 2'd3 || (dm == 2'b11 && sb == 2'd1));
        end
        return {pb_e, pa_e};
    endfunction
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(4'he, 8'h01);
        rc(4'hf, 8'h00);
        rc(4'hd, 8'h00);
        rc(4'h3, 8'h00);
        r = $random(seed);
        t = r[7:0];
        bus(1'b1, 4'hf, t);
        rc(4'hf, t);
        chk("thr_out", {24'h0, lthr}, {24'h0, t});
        txd <= 1'b1; lock <= 1'b1;
        tk(8);
        rc(4'he, 8'h23);
        chk("lock_pin", {31'h0, lpin}, 32'h1);
        txd <= 1'b0; lock <= 1'b0;
        tk(8);
        rc(4'he, 8'h03);
        chk("lock_pin", {31'h0, lpin}, 32'h0);
        bus(1'b1, 4'he, 8'h00);
        rc(4'he, 8'h02);
        chk("lock_pin", {31'h0, lpin}, 32'h1);
        bus(1'b1, 4'he, 8'h02);
        rc(4'he, 8'h00);
        for (int m = 0; m < 3; m++) begin
            dm <= (m == 0) ? 2'b01 : ((m == 1) ? 2'b11 : 2'b10);
            ovr <= 1'b1;
            @(posedge clk);
            ovr <= 1'b0;
            tk(2);
            rc(4'he, 8'h10);
            f0 = fcnt;
            bus(1'b1, 4'he, 8'h10);
            tk(2);
            chk("flush", fcnt, f0 + ((m < 2) ? 1 : 0));
            rc(4'he, 8'h00);
        end
        ovr <= 1'b1;
        bus(1'b1, 4'he, 8'h10);
        ovr <= 1'b0;
        rc(4'he, 8'h10);
        bus(1'b1, 4'he, 8'h10);
        bus(1'b1, 4'hf, 8'h40);
        bus(1'b1, 4'he, 8'h08);
        lvl <= 8'h40;
        tk(4);
        rc(4'he, 8'h0c);
        lvl <= 8'h00;
        bus(1'b1, 4'he, 8'h08);
        rc(4'he, 8'h0c);
        bus(1'b1, 4'he, 8'h04);
        lvl <= 8'h40;
        tk(4);
        rc(4'he, 8'h00);
        sdet <= 1'b1;
        @(posedge clk);
        sdet <= 1'b0;
        tk(2);
        rc(4'he, 8'h40);
        chk("fill", {31'h0, fen}, 32'h1);
        bus(1'b1, 4'he, 8'h40);
        rc(4'he, 8'h00);
        bus(1'b1, 4'he, 8'h80);
        bus(1'b1, 4'he, 8'hc0);
        chk("fill", {31'h0, fen}, 32'h1);
        bus(1'b1, 4'he, 8'h80);
        rc(4'he, 8'h80);
        chk("fill", {31'h0, fen}, 32'h0);
        txm <= 1'b1;
        dm <= 2'b01;
        f0 = ts;
        bus(1'b1, 4'hd, 8'h08);
        cnt <= 7'h01;
        tk(3);
        chk("tx_start", ts, f0 + 1);
        dm <= 2'b00;
        rclk <= 1'b1;
        f0 = br;
        tk(8);
        chk("b_rise", br, f0 + 1);
        lvl <= 8'h00;
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            a = r[7:6];
            b = r[5:4];
            ta = r[3];
            bus(1'b1, 4'hd, {a, b, ta, 3'b000});
            r = $random(seed);
            {pat, sdet, drdy, byt, crc, nm, full, nme, txm, rclk} <= r[9:0];
            dm <= r[11:10];
            sby <= r[12] & r[13];
            thr <= r[21:16];
            cnt <= {1'b0, r[21:16]} + {5'h00, r[23:22]};
            tk(6);
            e = pins(a, b, ta);
            chk("pins", {30'h0, pb, pa}, {30'h0, e});
            rc(4'hd, {a, b, ta, 1'b0, full, cnt != 7'h00});
        end
        stop_test();
    end
endmodule // tb
`default_nettype wire
